// *** include/xram_map.svh ***
// xram_map.svh: offsets, ram sizes, reset values and timing counts for the xram access block
// assumes inclusion by bare name from a design file; definitions only
`ifndef XRAM_MAP_SVH
`define XRAM_MAP_SVH
`define XRAM_FIFO_BASE 16'h0400
`define XRAM_FIFO_LAST 16'h07ff
`define XRAM_PAGE_RST 8'h00
`define XRAM_DATA_POINTER_RST 16'h0000
`define XRAM_ONCHIP_4K 16'h1000
`define XRAM_ONCHIP_2K 16'h0800
`define XRAM_CLK_PERIOD_NS 10
`define XRAM_FIFO_WAIT_NS 40
`define XRAM_FIFO_WAIT_CYC ((`XRAM_FIFO_WAIT_NS + `XRAM_CLK_PERIOD_NS - 1) / `XRAM_CLK_PERIOD_NS)
`define XRAM_EXT_WAIT_CYC 2
`endif

// *** include/xram_pkg.sv ***
// xram_pkg: types shared by the xram access block
// assumes xram_map.svh supplies the numeric constants
package xram_pkg;
  typedef enum logic [1:0] {
    XRAM_MODE_ONCHIP = 2'h0,
    XRAM_MODE_SPLIT_NOBANK = 2'h1,
    XRAM_MODE_SPLIT_BANK = 2'h2,
    XRAM_MODE_OFFCHIP = 2'h3
  } xram_mode_e;
  typedef enum logic [3:0] {
    XRAM_ST_IDLE = 4'h1,
    XRAM_ST_ONCHIP = 4'h2,
    XRAM_ST_FIFO = 4'h4,
    XRAM_ST_EXT = 4'h8
  } xram_state_e;
  // one external move request from the core
  typedef struct packed {
    logic use_ptr;
    logic use_one;
    logic write;
    logic [7:0] wdata;
  } xram_req_s;
  // configuration bits
  typedef struct packed {
    logic fifo_window_enable;
    logic multiplex_select;
    xram_mode_e mode;
  } xram_cfg_s;
endpackage

// *** hw/xram_ext_mem_interface_access.sv ***
// xram_ext_mem_interface_access: address formation and routing of external moves
// assumes a core that holds a request until done, fifo ram answers in fixed cycles
// the pin image stands for ports 4, 3, 2 and 1; output modes stay with the port logic
// What this block does
// - on-chip ram mapped into external data space
// - external moves target xram by default
// - pointer move uses full 16-bit data pointer
// - data pointer readable, writable as two bytes
// - byte move: page register high, index low
// - fifo window maps fifo ram at 0x0400-0x07ff
// - window hides normal xram at those addresses
// - fifo access takes more cycles than xram
// - external pins on ports 4, 3, 2, 1
// - pins claimed only during off-chip move
// - input pins undriven during external move
// - pin output mode left to port registers
// - four memory modes plus multiplexed option
// - multiplex select: 0 muxed, 1 separate
// - page register resets zero, selects page
`timescale 1ns/1ps
`include "xram_map.svh"
module xram_ext_mem_interface_access #(
  parameter bit BIG_RAM = 1'b1,
  parameter int FIFO_WAIT = `XRAM_FIFO_WAIT_CYC,
  parameter int EXT_WAIT = `XRAM_EXT_WAIT_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // core request
  input wire logic req_valid,
  input wire xram_pkg::xram_req_s req,
  output logic req_done,
  output logic [7:0] rdata_q,
  // index registers and special register access
  input wire logic [7:0] index_reg_zero,
  input wire logic [7:0] index_reg_one,
  input wire logic dph_we,
  input wire logic dpl_we,
  input wire logic data_pointer_we,
  input wire logic page_we,
  input wire logic [15:0] sfr_wdata,
  output logic [7:0] data_pointer_high,
  output logic [7:0] data_pointer_low,
  output logic [7:0] xram_page_select,
  // configuration
  input wire xram_pkg::xram_cfg_s cfg,
  // usb fifo ram
  output logic fifo_en,
  output logic fifo_we,
  output logic [9:0] fifo_addr,
  output logic [7:0] fifo_wdata,
  input wire logic [7:0] fifo_rdata,
  // external pins (ports 4,3,2,1 image), enables high while driven
  output logic ext_mem_interface_active,
  output logic [15:0] ext_addr_o,
  output logic ext_addr_oe,
  output logic [7:0] ext_data_o,
  output logic ext_data_oe,
  input wire logic [7:0] ext_data_i,
  output logic ext_wr_n_o,
  output logic ext_rd_n_o,
  output logic ext_ale_o
);
  // on-chip ram size by variant
  localparam logic [15:0] ONCHIP_SIZE = BIG_RAM ? `XRAM_ONCHIP_4K : `XRAM_ONCHIP_2K;

  // sequencer, pointer and latched request
  xram_pkg::xram_state_e state_q;
  logic [15:0] data_pointer_q;
  logic [7:0] page_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic write_q;
  logic [7:0] cnt_q;
  // storage sized for the larger variant
  logic [7:0] ram [0:4095];
  // decode of the request as it stands
  logic [15:0] addr_d;
  logic in_fifo;
  logic off_chip;

  // true where an address falls outside the on-chip ram for the mode
  function automatic logic goes_off(input logic [15:0] a, input xram_pkg::xram_mode_e m);
    case (m)
      xram_pkg::XRAM_MODE_ONCHIP: goes_off = 1'b0;
      xram_pkg::XRAM_MODE_OFFCHIP: goes_off = 1'b1;
      default: goes_off = (a >= ONCHIP_SIZE);
    endcase
  endfunction

  // on-chip ram index; addresses past the variant's size alias back into it
  function automatic logic [11:0] ram_index(input logic [15:0] a);
    ram_index = 12'(a & (ONCHIP_SIZE - 16'h0001));
  endfunction

  // effective address
  always_comb begin
    if (req.use_ptr) begin
      addr_d = data_pointer_q;
    end else begin
      addr_d = {page_q, req.use_one ? index_reg_one : index_reg_zero};
    end
  end
  // window decode; clear window leaves range as ordinary xram
  assign in_fifo = cfg.fifo_window_enable && addr_d >= `XRAM_FIFO_BASE
    && addr_d <= `XRAM_FIFO_LAST;
  assign off_chip = !in_fifo && goes_off(addr_d, cfg.mode);

  // data pointer and page register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_pointer_q <= `XRAM_DATA_POINTER_RST;
      page_q <= `XRAM_PAGE_RST;
    end else begin
      // whole-pointer write wins over the byte writes
      if (data_pointer_we) begin
        data_pointer_q <= sfr_wdata;
      end else begin
        if (dph_we) data_pointer_q[15:8] <= sfr_wdata[7:0];
        if (dpl_we) data_pointer_q[7:0] <= sfr_wdata[7:0];
      end
      if (page_we) page_q <= sfr_wdata[7:0];
    end
  end
  // register readback
  assign data_pointer_high = data_pointer_q[15:8];
  assign data_pointer_low = data_pointer_q[7:0];
  assign xram_page_select = page_q;

  // access sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= xram_pkg::XRAM_ST_IDLE;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      write_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      case (state_q)
        xram_pkg::XRAM_ST_IDLE: begin
          // request fields latched so the core is free once done
          if (req_valid) begin
            addr_q <= addr_d;
            wdata_q <= req.wdata;
            write_q <= req.write;
            // window tested first so it hides on-chip and off-chip xram alike
            if (in_fifo) begin
              state_q <= xram_pkg::XRAM_ST_FIFO;
              cnt_q <= 8'(FIFO_WAIT);
            end else if (off_chip) begin
              state_q <= xram_pkg::XRAM_ST_EXT;
              cnt_q <= 8'(EXT_WAIT);
            end else begin
              state_q <= xram_pkg::XRAM_ST_ONCHIP;
            end
          end
        end
        xram_pkg::XRAM_ST_ONCHIP: state_q <= xram_pkg::XRAM_ST_IDLE;
        // stretched accesses count down; done shows in the zero cycle
        xram_pkg::XRAM_ST_FIFO, xram_pkg::XRAM_ST_EXT: begin
          if (cnt_q == 8'h00) state_q <= xram_pkg::XRAM_ST_IDLE;
          else cnt_q <= cnt_q - 8'h01;
        end
        default: state_q <= xram_pkg::XRAM_ST_IDLE;
      endcase
    end
  end
  // done pulses in the last cycle of every access
  assign req_done = (state_q == xram_pkg::XRAM_ST_ONCHIP)
    || ((state_q == xram_pkg::XRAM_ST_FIFO || state_q == xram_pkg::XRAM_ST_EXT)
    && cnt_q == 8'h00);

  // on-chip ram array, index masked to the variant's size
  always_ff @(posedge clock) begin
    if (state_q == xram_pkg::XRAM_ST_ONCHIP && write_q) begin
      ram[ram_index(addr_q)] <= wdata_q;
    end
  end

  // read data capture, taken while the source still presents it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
    end else if (req_done && !write_q) begin
      case (state_q)
        xram_pkg::XRAM_ST_FIFO: rdata_q <= fifo_rdata;
        xram_pkg::XRAM_ST_EXT: rdata_q <= ext_data_i;
        default: rdata_q <= ram[ram_index(addr_q)];
      endcase
    end
  end

  // fifo ram port, held for the whole stretched access
  assign fifo_en = (state_q == xram_pkg::XRAM_ST_FIFO);
  // one write strobe, in the final cycle, so a byte lands once
  assign fifo_we = fifo_en && write_q && cnt_q == 8'h00;
  assign fifo_addr = addr_q[9:0];
  assign fifo_wdata = wdata_q;

  // external pins claimed only during an off-chip move; drive mode left to ports
  assign ext_mem_interface_active = (state_q == xram_pkg::XRAM_ST_EXT);
  assign ext_addr_o = ext_mem_interface_active ? addr_q : 16'h0000;
  assign ext_addr_oe = ext_mem_interface_active;
  // multiplexed bus puts the low address on the data pins first
  assign ext_data_o = cfg.multiplex_select ? wdata_q
    : ((cnt_q == 8'(EXT_WAIT)) ? addr_q[7:0] : wdata_q);
  // data drivers stay off whenever the pins act as inputs
  assign ext_data_oe = ext_mem_interface_active && (write_q
    || (!cfg.multiplex_select && cnt_q == 8'(EXT_WAIT)));
  // address latch strobe only on the multiplexed bus
  assign ext_ale_o = ext_mem_interface_active && !cfg.multiplex_select
    && cnt_q == 8'(EXT_WAIT);
  // strobes wait out the address cycle
  assign ext_wr_n_o = !(ext_mem_interface_active && write_q && cnt_q != 8'(EXT_WAIT));
  assign ext_rd_n_o = !(ext_mem_interface_active && !write_q && cnt_q != 8'(EXT_WAIT));
endmodule // xram_ext_mem_interface_access

// *** sim/xram_ext_mem_interface_access_chk.sv ***
// xram_ext_mem_interface_access_chk: port assertions for the xram access block
// assumes bind into xram_ext_mem_interface_access, one clock, rstn active low
`timescale 1ns/1ps
module xram_ext_mem_interface_access_chk (
  input logic clock, rstn, req_valid, req_done, data_pointer_we, fifo_en,
  input xram_pkg::xram_req_s req,
  input xram_pkg::xram_cfg_s cfg,
  input logic [7:0] index_reg_zero, index_reg_one, data_pointer_high, data_pointer_low,
  input logic [7:0] xram_page_select, ext_data_o,
  input logic [15:0] sfr_wdata,
  input logic [9:0] fifo_addr,
  input logic ext_mem_interface_active, ext_addr_oe, ext_data_oe, ext_wr_n_o, ext_rd_n_o, ext_ale_o
);
  logic [15:0] addr;
  // address the core is asking for
  assign addr = req.use_ptr ? {data_pointer_high, data_pointer_low}
    : {xram_page_select, req.use_one ? index_reg_one : index_reg_zero};
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_fifo_addr_map: assert property (req_valid && fifo_en |->
    addr[15:10] == 6'h01 && fifo_addr == addr[9:0]) else $error("fifo address off");
  a_fifo_window_gate: assert property (fifo_en |-> cfg.fifo_window_enable)
    else $error("fifo used with window off");
  a_window_hides_ext: assert property (req_valid && cfg.fifo_window_enable
    && addr[15:10] == 6'h01 |-> !ext_mem_interface_active) else $error("pins in window");
  a_ale_muxed_only: assert property (ext_ale_o |-> !cfg.multiplex_select
    && ext_data_oe && ext_data_o == addr[7:0]) else $error("address latch");
  a_pins_when_claimed: assert property (ext_addr_oe || ext_data_oe || !ext_wr_n_o
    || !ext_rd_n_o |-> ext_mem_interface_active) else $error("pins used unclaimed");
  a_read_bus_free: assert property (!ext_rd_n_o |-> !ext_data_oe) else $error("data driven");
  a_onchip_no_pins: assert property (cfg.mode == xram_pkg::XRAM_MODE_ONCHIP
    |-> !ext_mem_interface_active) else $error("pins claimed on-chip");
  a_fifo_slow_done: assert property ($rose(fifo_en) |-> !req_done [*2])
    else $error("fifo access too fast");
  a_data_pointer_pair_write: assert property (data_pointer_we |=>
    {data_pointer_high, data_pointer_low} == $past(sfr_wdata)) else $error("pointer write");
  a_write_drives_data: assert property (!ext_wr_n_o |-> ext_data_oe
    && ext_data_o == req.wdata) else $error("write data");
endmodule // xram_ext_mem_interface_access_chk
bind xram_ext_mem_interface_access xram_ext_mem_interface_access_chk u_chk (.*);

// *** sim/xram_far_model.sv ***
// xram_far_model: off-chip memory and fifo ram seen from the block
// assumes active low strobes, one stored byte per side; parked data lines read high
`timescale 1ns/1ps
module xram_far_model (
  input wire logic clock, rstn, fifo_en, fifo_we, ext_rd_n_o, ext_wr_n_o,
  input wire logic [9:0] fifo_addr,
  input wire logic [7:0] fifo_wdata, ext_data_o,
  input wire logic [15:0] ext_addr_o,
  output logic [7:0] fifo_rdata, ext_data_i
);
  logic [15:0] ext_a_q;
  logic [7:0] ext_d_q, fifo_d_q;
  logic [9:0] fifo_a_q;
  // last off-chip byte written, kept for read-back
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ext_a_q <= 16'hffff;
      ext_d_q <= 8'h00;
    end else if (!ext_wr_n_o) begin
      ext_a_q <= ext_addr_o;
      ext_d_q <= ext_data_o;
    end
  end
  // last fifo byte written, kept for read-back
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fifo_a_q <= 10'h3ff;
      fifo_d_q <= 8'h00;
    end else if (fifo_we) begin
      fifo_a_q <= fifo_addr;
      fifo_d_q <= fifo_wdata;
    end
  end
  // released data lines show the parked port latch level
  assign ext_data_i = ext_rd_n_o ? 8'hff
    : (ext_addr_o == ext_a_q ? ext_d_q : ext_addr_o[7:0] ^ 8'h5a);
  // fifo side clock assumed fast enough to answer in fixed time
  assign fifo_rdata = !fifo_en ? ~fifo_d_q
    : (fifo_addr == fifo_a_q ? fifo_d_q : ~fifo_addr[7:0]);
endmodule // xram_far_model

// *** sim/xram_ext_mem_interface_access_test.sv ***
// xram_ext_mem_interface_access_test: directed sequences of moves and register writes
// assumes xram_far_model on the far side and the bound checker
`timescale 1ns/1ps
module xram_ext_mem_interface_access_test;
  localparam int FW = 4;
  localparam int EW = 2;
  logic clock, rstn, req_valid, req_done, dph_we, dpl_we, data_pointer_we, page_we, fifo_en, fifo_we;
  logic ext_mem_interface_active, ext_addr_oe, ext_data_oe, ext_wr_n_o, ext_rd_n_o, ext_ale_o;
  logic [7:0] rdata_q, index_reg_zero, index_reg_one, data_pointer_high, data_pointer_low;
  logic [7:0] xram_page_select, fifo_wdata, fifo_rdata, ext_data_o, ext_data_i;
  logic [15:0] sfr_wdata, ext_addr_o;
  logic [9:0] fifo_addr;
  xram_pkg::xram_req_s req;
  xram_pkg::xram_cfg_s cfg;
  int fail_count = 0, checks_done = 0, n;
  xram_ext_mem_interface_access #(.BIG_RAM(1'b1), .FIFO_WAIT(FW), .EXT_WAIT(EW)) uut (.*);
  xram_far_model far (.*);
  task automatic chk(input string s, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  // one register write pulse {data_pointer, high, low, page}
  task automatic sfr(input logic [3:0] we, input logic [15:0] d);
    {data_pointer_we, dph_we, dpl_we, page_we} = we;
    sfr_wdata = d;
    @(negedge clock);
    {data_pointer_we, dph_we, dpl_we, page_we} = 4'h0;
    @(negedge clock);
  endtask
  // one move {use_ptr, use_one, write}, counts cycles to done
  task automatic mv(input logic [2:0] k, input logic [7:0] d);
    req = {k, d};
    req_valid = 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (req_done !== 1'b1 && n < 50);
    if (req_done !== 1'b1) begin
      fail_count++;
      $display("unexpected done expected 1 seen %b", req_done);
    end
    req_valid = 1'b0;
    @(negedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict;
  end
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    cfg = '0;
    index_reg_zero = 8'h34;
    index_reg_one = 8'h56;
    {data_pointer_we, dph_we, dpl_we, page_we} = 4'h0;
    sfr_wdata = 16'h0000;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    chk("page", 16'h0000, {8'h00, xram_page_select});
    sfr(4'h4, 16'h0012);
    sfr(4'h2, 16'h0034);
    chk("data_pointer", 16'h1234, {data_pointer_high, data_pointer_low});
    sfr(4'h8, 16'h0456);
    sfr(4'h1, 16'h0004);
    chk("page", 16'h0004, {8'h00, xram_page_select});
    mv(3'b101, 8'ha5);
    chk("cycles", 16'h0001, 16'(n));
    mv(3'b010, 8'h00);
    chk("rdata", 16'h00a5, {8'h00, rdata_q});
    cfg.fifo_window_enable = 1'b1;
    mv(3'b100, 8'h00);
    chk("cycles", 16'(FW + 1), 16'(n));
    chk("rdata", 16'h00a9, {8'h00, rdata_q});
    mv(3'b101, 8'h3c);
    cfg.fifo_window_enable = 1'b0;
    mv(3'b100, 8'h00);
    chk("rdata", 16'h00a5, {8'h00, rdata_q});
    for (int m = 1; m < 3; m++) begin
      cfg.mode = xram_pkg::xram_mode_e'(m);
      mv(3'b100, 8'h00);
      chk("rdata", 16'h00a5, {8'h00, rdata_q});
    end
    // strobe pins skipped in the crossbar, latches parked high, outside this block
    cfg.multiplex_select = 1'b1;
    sfr(4'h1, 16'h0012);
    mv(3'b000, 8'h00);
    chk("cycles", 16'(EW + 1), 16'(n));
    chk("rdata", 16'h006e, {8'h00, rdata_q});
    chk("claim", 16'h0000, {15'h0000, ext_mem_interface_active});
    cfg.multiplex_select = 1'b0;
    cfg.mode = xram_pkg::XRAM_MODE_OFFCHIP;
    mv(3'b001, 8'h77);
    chk("cycles", 16'(EW + 1), 16'(n));
    mv(3'b000, 8'h00);
    chk("rdata", 16'h0077, {8'h00, rdata_q});
    cfg.fifo_window_enable = 1'b1;
    mv(3'b100, 8'h00);
    chk("rdata", 16'h003c, {8'h00, rdata_q});
    print_verdict;
  end
endmodule // xram_ext_mem_interface_access_test
